// >>> logic/dmeg_pkg.sv
// Constants for the debug attach gating block.
// Assumes one 20 MHz system clock and an async active-high reset.
// Contract
// R1: Attach only from boost or normal full-power, running/sleeping
// R2: No attach in restricted supply, back-bias, transition; code attaches in boost at any supply
// R3: Probe attaches at full power, then restricts
// R4: Probe sets debugger enable after attaching
// R5: Attached: boost and normal never swap
// R6: Attached: back-bias moves emulated, normal power kept
// R7: Probe sets debugger enable before back-bias
// R8: Probe sets debugger enable before restricted supply
// R9: Low power entry allowed while attached
// R10: Probe sets debugger enable before low power
// R11: Bus granted only running/sleeping, no transition
// R12: Wake request bit wakes chip from low power
// R13: Halt plus wake wakes without execution
// R14: New unlock code applies after pin/software reset
// R15: Probe loads new key just before reset
// R16: After key overwrite, software reset ignored
// R17: Halt bit halts; clears on write 0/halted
// R18: Probe writes wake and halt bits alike
// R19: Probe writes key words in ascending order
// R20: Disallowed attach request ignored without effect
package dmeg_pkg;
  localparam logic [1:0] PCM_BOOST = 2'h0;
  localparam logic [1:0] PCM_NORMAL = 2'h1;
  localparam logic [1:0] PCM_BACK_BIAS = 2'h2;
  localparam logic [1:0] SUP_FULL = 2'h0;
  localparam logic [1:0] SUP_EXT_FLASH = 2'h1;
  localparam logic [1:0] SUP_MINIMUM = 2'h2;
  localparam logic [2:0] LP_OPERATING = 3'h0;
  localparam logic [2:0] LP_SLEEP = 3'h1;
  localparam logic [2:0] LP_SNOOZE = 3'h2;
  localparam logic [2:0] LP_SW_STANDBY = 3'h3;
  localparam logic [2:0] LP_DEEP_STANDBY = 3'h4;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_STATUS = 12'h400;
  localparam logic [11:0] OFS_CONTROL = 12'h410;
  localparam logic [11:0] OFS_KEY0 = 12'h420;
  localparam logic [11:0] OFS_DBG_ENABLE = 12'h430;
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_WAKE_BIT = 8;
  localparam int STAT_AUTH_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam int STAT_STOPPED_BIT = 2;
  localparam int STAT_ATTACHED_BIT = 4;
  localparam int STAT_BUS_BIT = 5;
  localparam int STAT_BB_EMU_BIT = 6;
  localparam logic [127:0] CODE_RESET =
    128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF;
  typedef enum logic [2:0] {
    ST_DETACHED = 3'h1,
    ST_ATTACHED = 3'h2,
    ST_WAKING = 3'h4
  } dmeg_state_type;
endpackage : dmeg_pkg

// >>> logic/dmeg_sync.sv
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes the caller reads only the output.
`timescale 1ns/100ps
`default_nettype none
module dmeg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : dmeg_sync
`default_nettype wire

// >>> logic/dmeg_gate_check.sv
// Decodes the power state into attach and bus permissions.
// Assumes power state inputs are on the system clock.
`timescale 1ns/100ps
`default_nettype none
module dmeg_gate_check
  import dmeg_pkg::*;
(
  input wire logic [1:0] pcm,
  input wire logic [1:0] supply,
  input wire logic [2:0] lp,
  input wire logic in_transition,
  output logic entry_ok,
  output logic bus_ok
);
  logic running;
  always_comb begin
    running = (lp == LP_OPERATING) || (lp == LP_SLEEP);
    // Back-bias excluded; restricted supply excluded only in normal mode, not in boost
    entry_ok = running && !in_transition && ((pcm == PCM_BOOST) ||
      (pcm == PCM_NORMAL && supply == SUP_FULL)); // R1 R2
    bus_ok = running && !in_transition && (pcm == PCM_BOOST ||
      pcm == PCM_NORMAL || pcm == PCM_BACK_BIAS); // R11
  end
endmodule : dmeg_gate_check
`default_nettype wire

// >>> logic/dmeg_top.sv
// Gates debug attach, power mode moves, bus access and wake.
// Assumes power state and CPU status on CLK; probe pins asynchronous.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dmeg_top
  import dmeg_pkg::*;
#(
  parameter int KEY_WORDS = 4
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic LINK_CLK,
  input wire logic ATTACH_REQ,
  input wire logic RESET_PIN_N,
  input wire logic SW_RESET_REQ,
  input wire logic [1:0] POWER_CTRL_MODE,
  input wire logic [1:0] SUPPLY_MODE,
  input wire logic [2:0] LP_STATE,
  input wire logic MODE_TRANSITION,
  input wire logic PCM_REQ,
  input wire logic [1:0] PCM_TARGET,
  input wire logic LP_REQ,
  input wire logic CPU_HALTED,
  input wire logic CODE_WR,
  input wire logic [127:0] CODE_NEW,
  output logic ATTACHED,
  output logic BUS_GRANT,
  output logic PCM_ACCEPT,
  output logic PCM_REFUSE,
  output logic BB_EMULATED,
  output logic LP_GRANT,
  output logic WAKE_REQ,
  output logic HALT_REQ,
  output logic SYS_RESET,
  output logic DEBUGGER_ENABLE
);
  dmeg_state_type state;
  dmeg_state_type next_state;
  logic link_clk_s, link_req_s, reset_pin_s, link_clk_d;
  logic link_edge, entry_ok, bus_ok, low_power;
  logic wake_bit, halt_bit, key_overwritten, sys_rst_evt;
  logic [31:0] key [KEY_WORDS];
  logic [127:0] stored_unlock_code, pending_code;
  logic [127:0] key_flat;
  logic wr_ctrl, wr_dbg;
  logic [31:0] status_word;

  // Link clock is only sampled, never used as a clock
  dmeg_sync #(.WIDTH(2), .INIT(2'h0)) u_link_sync (
    .clk(CLK),
    .reset(RESET),
    .din({LINK_CLK, ATTACH_REQ}),
    .dout({link_clk_s, link_req_s})
  );
  dmeg_sync #(.WIDTH(1), .INIT(1'h1)) u_pin_sync (
    .clk(CLK),
    .reset(RESET),
    .din(RESET_PIN_N),
    .dout(reset_pin_s)
  );
  dmeg_gate_check u_check (
    .pcm(POWER_CTRL_MODE),
    .supply(SUPPLY_MODE),
    .lp(LP_STATE),
    .in_transition(MODE_TRANSITION),
    .entry_ok(entry_ok),
    .bus_ok(bus_ok)
  );

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      link_clk_d <= 1'b0;
    end else begin
      link_clk_d <= link_clk_s;
    end
  end

  always_comb begin
    link_edge = link_clk_s && !link_clk_d;
    low_power = (LP_STATE == LP_SNOOZE) || (LP_STATE == LP_SW_STANDBY) ||
      (LP_STATE == LP_DEEP_STANDBY);
    wr_ctrl = WR && (ADDR == OFS_CONTROL);
    wr_dbg = WR && (ADDR == OFS_DBG_ENABLE);
    // Pin reset always counts; software reset only before key overwrite
    sys_rst_evt = !reset_pin_s || (SW_RESET_REQ && !key_overwritten); // R16
    for (int i = 0; i < KEY_WORDS; i++) begin
      key_flat[32*i +: 32] = key[i];
    end
  end

  // Attach state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_DETACHED: begin
        // Refused request leaves no trace
        if (link_edge && link_req_s && entry_ok) begin // R1 R2 R20
          next_state = ST_ATTACHED;
        end
      end
      ST_ATTACHED: begin
        if (link_edge && !link_req_s) begin
          next_state = ST_DETACHED;
        end else if (wake_bit && low_power) begin // R12
          next_state = ST_WAKING;
        end
      end
      ST_WAKING: begin
        if (link_edge && !link_req_s) begin
          next_state = ST_DETACHED;
        end else if (!low_power) begin
          next_state = ST_ATTACHED;
        end
      end
      default: begin
        next_state = ST_DETACHED;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= ST_DETACHED;
    end else begin
      state <= next_state;
    end
  end

  // Control bits; a halt write of 1 beats a same-cycle halted clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      halt_bit <= 1'b0;
      wake_bit <= 1'b0;
      DEBUGGER_ENABLE <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        halt_bit <= WDATA[CTRL_HALT_BIT]; // R17
        wake_bit <= WDATA[CTRL_WAKE_BIT]; // R12
      end else if (CPU_HALTED) begin
        halt_bit <= 1'b0; // R17
      end
      if (wr_dbg) begin
        DEBUGGER_ENABLE <= WDATA[0];
      end
    end
  end

  // Key words; any write marks the key as overwritten until reset
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < KEY_WORDS; i++) begin
        key[i] <= 32'hFFFF_FFFF;
      end
      key_overwritten <= 1'b0;
    end else begin
      for (int i = 0; i < KEY_WORDS; i++) begin
        if (WR && ADDR == OFS_KEY0 + 12'(4 * i)) begin
          key[i] <= WDATA;
        end
      end
      if (sys_rst_evt) begin
        key_overwritten <= 1'b0;
      end else if (WR && ADDR >= OFS_KEY0 &&
        ADDR < OFS_KEY0 + 12'(4 * KEY_WORDS)) begin
        key_overwritten <= 1'b1; // R16
      end
    end
  end

  // New code waits in pending until a system reset takes it over
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pending_code <= CODE_RESET;
      stored_unlock_code <= CODE_RESET;
      SYS_RESET <= 1'b0;
    end else begin
      if (CODE_WR) begin
        pending_code <= CODE_NEW;
      end
      if (sys_rst_evt) begin
        stored_unlock_code <= pending_code; // R14
      end
      SYS_RESET <= sys_rst_evt; // R14 R16
    end
  end

  // Power mode requests while attached
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PCM_ACCEPT <= 1'b0;
      PCM_REFUSE <= 1'b0;
      BB_EMULATED <= 1'b0;
      LP_GRANT <= 1'b0;
    end else begin
      PCM_ACCEPT <= 1'b0;
      PCM_REFUSE <= 1'b0;
      LP_GRANT <= LP_REQ; // R9
      if (state == ST_DETACHED) begin
        BB_EMULATED <= 1'b0;
        PCM_ACCEPT <= PCM_REQ;
      end else if (PCM_REQ) begin
        if (PCM_TARGET == PCM_BACK_BIAS || POWER_CTRL_MODE == PCM_BACK_BIAS
          || BB_EMULATED) begin
          // Flag follows, real supply stays at normal
          BB_EMULATED <= (PCM_TARGET == PCM_BACK_BIAS); // R6
        end else if (PCM_TARGET != POWER_CTRL_MODE) begin
          PCM_REFUSE <= 1'b1; // R5
        end else begin
          PCM_ACCEPT <= 1'b1;
        end
      end
    end
  end

  // Status outputs
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ATTACHED <= 1'b0;
      BUS_GRANT <= 1'b0;
      WAKE_REQ <= 1'b0;
      HALT_REQ <= 1'b0;
    end else begin
      ATTACHED <= (next_state != ST_DETACHED);
      BUS_GRANT <= (state == ST_ATTACHED) && bus_ok; // R11
      WAKE_REQ <= (state != ST_DETACHED) && wake_bit && low_power; // R12
      HALT_REQ <= halt_bit; // R13 R17
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_AUTH_BIT] = (key_flat == stored_unlock_code);
    status_word[STAT_SLEEP_BIT] = (LP_STATE == LP_SLEEP);
    status_word[STAT_STOPPED_BIT] = CPU_HALTED;
    status_word[STAT_ATTACHED_BIT] = (state != ST_DETACHED);
    status_word[STAT_BUS_BIT] = BUS_GRANT;
    status_word[STAT_BB_EMU_BIT] = BB_EMULATED;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 32'h0000_0000;
    end else begin
      RDATA <= 32'h0000_0000;
      if (RD) begin
        case (ADDR)
          OFS_STATUS: RDATA <= status_word;
          OFS_CONTROL: begin
            RDATA[CTRL_HALT_BIT] <= halt_bit;
            RDATA[CTRL_WAKE_BIT] <= wake_bit;
          end
          OFS_DBG_ENABLE: RDATA[0] <= DEBUGGER_ENABLE;
          default: begin
            for (int i = 0; i < KEY_WORDS; i++) begin
              if (ADDR == OFS_KEY0 + 12'(4 * i)) begin
                RDATA <= key[i];
              end
            end
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  a_entry_allowed: assert property ( // R1
    state == ST_DETACHED && next_state != ST_DETACHED |-> entry_ok)
    else $error("attach taken in a disallowed power state");
  a_entry_refused: assert property ( // R2
    state == ST_DETACHED && link_edge && link_req_s && !entry_ok
    |=> state == ST_DETACHED && !ATTACHED)
    else $error("attach not refused");
  a_refuse_quiet: assert property ( // R20
    state == ST_DETACHED && !entry_ok |=> state == ST_DETACHED &&
    !BB_EMULATED && !PCM_REFUSE)
    else $error("refused attach had a side effect");
  a_no_boost_swap: assert property ( // R5
    state != ST_DETACHED && PCM_REQ && !BB_EMULATED &&
    POWER_CTRL_MODE == PCM_NORMAL && PCM_TARGET == PCM_BOOST
    |=> PCM_REFUSE && !PCM_ACCEPT)
    else $error("boost move passed while attached");
  a_bb_emulated: assert property ( // R6
    state != ST_DETACHED && PCM_REQ && PCM_TARGET == PCM_BACK_BIAS
    |=> BB_EMULATED && !PCM_ACCEPT)
    else $error("back-bias move not emulated");
  a_lp_allowed: assert property ( // R9
    LP_REQ |=> LP_GRANT)
    else $error("low power entry blocked");
  a_bus_gate: assert property ( // R11
    BUS_GRANT |-> $past(bus_ok) && $past(state) == ST_ATTACHED)
    else $error("bus granted in a forbidden state");
  a_wake_req: assert property ( // R12
    state != ST_DETACHED && wake_bit && low_power ##1 low_power[*2]
    |-> WAKE_REQ)
    else $error("wake request missing");
  a_halt_clear: assert property ( // R17
    halt_bit && CPU_HALTED && !wr_ctrl |=> !halt_bit ##1 !HALT_REQ)
    else $error("halt bit not cleared after halt");
  a_code_at_reset: assert property ( // R14
    $changed(stored_unlock_code) |-> $past(sys_rst_evt))
    else $error("unlock code changed without reset");
  a_sw_reset_blocked: assert property ( // R16
    key_overwritten && reset_pin_s |=> !SYS_RESET)
    else $error("software reset taken after key overwrite");

  c_attach: cover property (state == ST_DETACHED ##1 state == ST_ATTACHED);
  c_bus: cover property (BUS_GRANT);
  c_bb_emul: cover property ($rose(BB_EMULATED));
  c_wake: cover property (state == ST_WAKING ##[1:20] state == ST_ATTACHED);
endmodule : dmeg_top
`default_nettype wire

// >>> bench/dmeg_probe_model.sv
// Probe model: link clock and attach level of a debug probe.
// Assumes the bench frames link traffic by raising run.
`timescale 1ns/100ps
`default_nettype none
module dmeg_probe_model (
  input wire logic run,
  input wire logic want,
  output logic LINK_CLK,
  output logic ATTACH_REQ
);
  // Clock stands still between frames, 400 ns inside them
  // Level moves with the falling edge, away from the sampling edge
  initial begin
    LINK_CLK = 1'b0;
    ATTACH_REQ = 1'b0;
    forever begin
      #200;
      if (LINK_CLK) begin
        ATTACH_REQ = want;
      end
      LINK_CLK = run ? ~LINK_CLK : 1'b0;
    end
  end
endmodule : dmeg_probe_model
`default_nettype wire

// >>> bench/dmeg_top_test.sv
// Bench for the debug attach gating block: one task per scenario.
// Assumes the probe model drives the link; the bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module dmeg_top_test;
  import dmeg_pkg::*;
  localparam logic [127:0] KEY = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978;
  logic CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0;
  logic [11:0] ADDR = 12'h000;
  logic [31:0] WDATA = 32'h0000_0000, RDATA;
  logic LINK_CLK, ATTACH_REQ, run = 1'b0, want = 1'b0;
  logic RESET_PIN_N = 1'b1, SW_RESET_REQ = 1'b0, MODE_TRANSITION = 1'b0;
  logic [1:0] POWER_CTRL_MODE = PCM_NORMAL, SUPPLY_MODE = SUP_FULL;
  logic [2:0] LP_STATE = LP_OPERATING;
  logic PCM_REQ = 1'b0, LP_REQ = 1'b0, CPU_HALTED = 1'b0, CODE_WR = 1'b0;
  logic [1:0] PCM_TARGET = PCM_NORMAL;
  logic [127:0] CODE_NEW = 128'h0;
  logic ATTACHED, BUS_GRANT, PCM_ACCEPT, PCM_REFUSE, BB_EMULATED, LP_GRANT;
  logic WAKE_REQ, HALT_REQ, SYS_RESET, DEBUGGER_ENABLE;
  int error_cnt = 0, total_checks = 0;
  wire logic [4:0] mon = {WAKE_REQ, BUS_GRANT, SYS_RESET, ~ATTACHED, ATTACHED};

  always #25 CLK = ~CLK;

  dmeg_probe_model dmeg_probe_model_inst (.run(run), .want(want),
    .LINK_CLK(LINK_CLK), .ATTACH_REQ(ATTACH_REQ));
  dmeg_top #(.KEY_WORDS(4)) dmeg_top_inst (.CLK(CLK), .RESET(RESET),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .LINK_CLK(LINK_CLK), .ATTACH_REQ(ATTACH_REQ), .RESET_PIN_N(RESET_PIN_N),
    .SW_RESET_REQ(SW_RESET_REQ), .POWER_CTRL_MODE(POWER_CTRL_MODE),
    .SUPPLY_MODE(SUPPLY_MODE), .LP_STATE(LP_STATE),
    .MODE_TRANSITION(MODE_TRANSITION), .PCM_REQ(PCM_REQ),
    .PCM_TARGET(PCM_TARGET), .LP_REQ(LP_REQ), .CPU_HALTED(CPU_HALTED),
    .CODE_WR(CODE_WR), .CODE_NEW(CODE_NEW), .ATTACHED(ATTACHED),
    .BUS_GRANT(BUS_GRANT), .PCM_ACCEPT(PCM_ACCEPT), .PCM_REFUSE(PCM_REFUSE),
    .BB_EMULATED(BB_EMULATED), .LP_GRANT(LP_GRANT), .WAKE_REQ(WAKE_REQ),
    .HALT_REQ(HALT_REQ), .SYS_RESET(SYS_RESET),
    .DEBUGGER_ENABLE(DEBUGGER_ENABLE));

  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic check(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // Bounded wait; a hang ends the run at once
  task automatic wait_hi(input int k, input int lim);
    int i;
    for (i = 0; i < lim && mon[k] !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    if (mon[k] !== 1'b1) begin
      error_cnt++;
      $display("unexpected timeout %0d expected 1 seen 0", k);
      results();
    end
  endtask : wait_hi

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string n, input logic [11:0] a,
                        input logic [31:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    check(n, RDATA, e);
  endtask : rd_chk

  task automatic set_pw(input logic [1:0] p, s, input logic [2:0] l,
                        input logic t);
    @(posedge CLK);
    POWER_CTRL_MODE <= p;
    SUPPLY_MODE <= s;
    LP_STATE <= l;
    MODE_TRANSITION <= t;
  endtask : set_pw

  task automatic no_attach(input logic [1:0] p, s, input logic [2:0] l,
                           input logic t);
    set_pw(p, s, l, t);
    repeat (40) @(posedge CLK);
    #1;
    check("attached", 32'(ATTACHED), 32'h0);
  endtask : no_attach

  task automatic pcm(input logic [1:0] t, input logic [1:0] e);
    @(posedge CLK);
    PCM_TARGET <= t;
    PCM_REQ <= 1'b1;
    @(posedge CLK);
    PCM_REQ <= 1'b0;
    #1;
    check("accept_refuse", 32'({PCM_ACCEPT, PCM_REFUSE}), 32'(e));
  endtask : pcm

  // Pulse stands only in the cycle after the request is taken
  task automatic sw_rst(input logic e);
    @(posedge CLK);
    SW_RESET_REQ <= 1'b1;
    @(posedge CLK);
    SW_RESET_REQ <= 1'b0;
    #1;
    check("sys_reset", 32'(SYS_RESET), 32'(e));
    @(posedge CLK);
    #1;
    check("sys_reset_end", 32'(SYS_RESET), 32'h0);
  endtask : sw_rst

  task automatic t_attach;
    set_pw(PCM_BOOST, SUP_FULL, LP_OPERATING, 1'b0);
    wait_hi(0, 40);
    check("attached", 32'(ATTACHED), 32'h1);
    want = 1'b0;
    wait_hi(1, 40);
    want = 1'b1;
    set_pw(PCM_NORMAL, SUP_FULL, LP_SLEEP, 1'b0);
    wait_hi(0, 40);
    check("attached", 32'(ATTACHED), 32'h1);
    run = 1'b0;
    set_pw(PCM_NORMAL, SUP_FULL, LP_OPERATING, 1'b0);
    wr(OFS_DBG_ENABLE, 32'h0000_0001);
    rd_chk("dbg_enable", OFS_DBG_ENABLE, 32'h0000_0001);
    check("dbg_enable_out", 32'(DEBUGGER_ENABLE), 32'h1);
    rd_chk("status", OFS_STATUS, 32'h0000_0031);
    rd_chk("unmapped", 12'h7F0, 32'h0000_0000);
  endtask : t_attach

  task automatic t_moves;
    pcm(PCM_BOOST, 2'b01);
    pcm(PCM_NORMAL, 2'b10);
    pcm(PCM_BACK_BIAS, 2'b00);
    check("bb_emulated", 32'(BB_EMULATED), 32'h1);
    check("attached", 32'(ATTACHED), 32'h1);
    pcm(PCM_NORMAL, 2'b00);
    check("bb_emulated", 32'(BB_EMULATED), 32'h0);
    set_pw(PCM_BOOST, SUP_FULL, LP_OPERATING, 1'b0);
    pcm(PCM_NORMAL, 2'b01);
    set_pw(PCM_NORMAL, SUP_EXT_FLASH, LP_OPERATING, 1'b0);
    repeat (2) @(posedge CLK);
    #1;
    check("attached", 32'(ATTACHED), 32'h1);
    set_pw(PCM_BACK_BIAS, SUP_FULL, LP_SLEEP, 1'b0);
    repeat (2) @(posedge CLK);
    #1;
    check("bus_grant", 32'(BUS_GRANT), 32'h1);
    set_pw(PCM_BACK_BIAS, SUP_FULL, LP_SLEEP, 1'b1);
    repeat (2) @(posedge CLK);
    #1;
    check("bus_grant", 32'(BUS_GRANT), 32'h0);
    set_pw(PCM_NORMAL, SUP_FULL, LP_OPERATING, 1'b0);
  endtask : t_moves

  task automatic t_low_power;
    @(posedge CLK);
    LP_REQ <= 1'b1;
    @(posedge CLK);
    #1;
    check("lp_grant", 32'(LP_GRANT), 32'h1);
    set_pw(PCM_NORMAL, SUP_FULL, LP_SNOOZE, 1'b0);
    repeat (2) @(posedge CLK);
    #1;
    check("bus_grant", 32'(BUS_GRANT), 32'h0);
    wr(OFS_CONTROL, 32'h0000_0101);
    wait_hi(4, 4);
    @(posedge CLK);
    #1;
    check("halt_req", 32'(HALT_REQ), 32'h1);
    set_pw(PCM_NORMAL, SUP_FULL, LP_OPERATING, 1'b0);
    LP_REQ <= 1'b0;
    wait_hi(3, 8);
    check("bus_grant", 32'(BUS_GRANT), 32'h1);
    @(posedge CLK);
    CPU_HALTED <= 1'b1;
    repeat (3) @(posedge CLK);
    rd_chk("control", OFS_CONTROL, 32'h0000_0100);
    check("halt_req", 32'(HALT_REQ), 32'h0);
    wr(OFS_CONTROL, 32'h0000_0000);
    CPU_HALTED <= 1'b0;
    rd_chk("control", OFS_CONTROL, 32'h0000_0000);
  endtask : t_low_power

  task automatic t_code;
    int i;
    rd_chk("key0", OFS_KEY0, 32'hFFFF_FFFF);
    @(posedge CLK);
    CODE_NEW <= KEY;
    CODE_WR <= 1'b1;
    @(posedge CLK);
    CODE_WR <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(OFS_KEY0 + 12'(4 * i), KEY[32 * i +: 32]);
    end
    rd_chk("status", OFS_STATUS, 32'h0000_0030);
    sw_rst(1'b0);
    @(posedge CLK);
    RESET_PIN_N <= 1'b0;
    wait_hi(2, 10);
    check("sys_reset", 32'(SYS_RESET), 32'h1);
    @(posedge CLK);
    RESET_PIN_N <= 1'b1;
    repeat (6) @(posedge CLK);
    rd_chk("status", OFS_STATUS, 32'h0000_0031);
    sw_rst(1'b1);
  endtask : t_code

  initial begin
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    run = 1'b1;
    want = 1'b1;
    no_attach(PCM_NORMAL, SUP_EXT_FLASH, LP_OPERATING, 1'b0);
    no_attach(PCM_NORMAL, SUP_MINIMUM, LP_OPERATING, 1'b0);
    no_attach(PCM_BACK_BIAS, SUP_FULL, LP_OPERATING, 1'b0);
    no_attach(PCM_NORMAL, SUP_FULL, LP_SNOOZE, 1'b0);
    no_attach(PCM_NORMAL, SUP_FULL, LP_SW_STANDBY, 1'b0);
    no_attach(PCM_NORMAL, SUP_FULL, LP_DEEP_STANDBY, 1'b0);
    no_attach(PCM_NORMAL, SUP_FULL, LP_OPERATING, 1'b1);
    t_attach();
    t_moves();
    t_low_power();
    t_code();
    results();
  end
endmodule : dmeg_top_test
`default_nettype wire
